/* File: pkg/event_word_consts.vh */
`ifndef EVENT_WORD_CONSTS_VH
`define EVENT_WORD_CONSTS_VH

// Word category and type tags
`define WORD_DEFINING_BIT    31
`define TYPE_TAG_HI          30
`define TYPE_TAG_LO          27
`define TAG_TRIG_TIME        4'h3
`define TAG_WINDOW           4'h4
`define TAG_HIT              4'h8
`define TAG_NO_DATA          4'hE
`define TAG_FILLER           4'hF

// Fixed word images
`define WINDOW_HEAD          8'hA0
`define CONT_HEAD            8'h00
`define NO_DATA_WORD         32'hF000_0000
`define FILLER_WORD          32'hF800_0000

// Hit word field positions
`define HIT_ZERO_BIT         23
`define HIT_CARRIER_BIT      22
`define HIT_CHIP_LO          19
`define HIT_CHAN_LO          12
`define HIT_TICK_LO          3

// Timestamp
`define STAMP_WIDTH          48
`define STAMP_HALF           24
`define STAMP_RESET          48'h0000_0000_0000

// Readout alignment: 1 means pad to 2 words, 3 means pad to 4 words
`define ALIGN_MASK_2         2'h1
`define ALIGN_MASK_4         2'h3

`endif

/* File: hdl/timestamp_counter.v */
`timescale 1ns/1ps
`include "event_word_consts.vh"

module timestamp_counter #(
   parameter WIDTH = `STAMP_WIDTH
) (
   input  wire             clk,
   input  wire             reset_n,
   output wire [WIDTH-1:0] count
);

   reg [WIDTH-1:0] count_reg;

   // Cleared under reset, counts from zero after release
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= {WIDTH{1'b0}};
      end else begin
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign count = count_reg;

endmodule // timestamp_counter

/* File: hdl/event_readout_word_encoder.v */
`timescale 1ns/1ps
`include "event_word_consts.vh"

module event_readout_word_encoder #(
   parameter TICK_WIDTH = 8,
   parameter CHIP_WIDTH = 3,
   parameter CHAN_WIDTH = 7,
   parameter AMP_WIDTH  = 3
) (
   input  wire                  clk,
   input  wire                  reset_n,
   // Event start: trigger with its window, a level taken only while idle
   input  wire                  trigger_valid,
   input  wire [TICK_WIDTH-1:0] window_open_tick,
   input  wire [TICK_WIDTH-1:0] window_close_tick,
   // Hit stream from event builder
   input  wire                  hit_valid,
   input  wire                  hit_last,
   input  wire                  carrier_select,
   input  wire [CHIP_WIDTH-1:0] frontend_chip_number,
   input  wire [CHAN_WIDTH-1:0] channel_index,
   input  wire [TICK_WIDTH-1:0] hit_crossing_tick,
   input  wire [AMP_WIDTH-1:0]  hit_amplitude,
   // Readout side
   input  wire                  block_end,
   input  wire                  align_four,
   input  wire                  read_req,
   output reg                   event_busy,
   output reg                   word_valid,
   output reg  [31:0]           word_data,
   output reg                   word_is_filler
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_TIME1 = 3'd1;
   localparam ST_TIME2 = 3'd2;
   localparam ST_WIN   = 3'd3;
   localparam ST_HITS  = 3'd4;
   localparam ST_PAD   = 3'd5;

   wire [`STAMP_WIDTH-1:0] stamp;

   reg  [2:0]              state_reg;
   reg  [2:0]              state_next;
   reg  [`STAMP_WIDTH-1:0] stamp_reg;
   reg  [TICK_WIDTH-1:0]   open_reg;
   reg  [TICK_WIDTH-1:0]   close_reg;
   reg  [1:0]              count_reg;
   reg  [1:0]              align_reg;
   reg  [31:0]             word_next;
   reg                     valid_next;
   reg                     filler_next;
   reg  [31:0]             hit_word;
   wire [1:0]              align_mask;
   reg  [31:0]             time_hi_word;
   reg  [31:0]             time_lo_word;
   reg  [31:0]             window_word;
   reg  [31:0]             no_data_word;
   reg  [31:0]             filler_word;
   wire                    event_start;
   wire                    block_aligned;
   wire                    pad_needed;
   wire                    pad_start;
   wire                    block_close;
   wire                    pad_done;

   timestamp_counter #(
      .WIDTH (`STAMP_WIDTH)
   ) u_stamp (
      .clk     (clk),
      .reset_n (reset_n),
      .count   (stamp)
   );

   assign align_mask = align_four ? `ALIGN_MASK_4 : `ALIGN_MASK_2;

   // Pad decision uses the modulus asked for with this block end
   assign event_start   = (state_reg == ST_IDLE) && trigger_valid;
   assign block_aligned = ((count_reg & align_mask) == 2'b00);
   assign pad_needed    = block_end && !block_aligned;
   assign pad_start     = (state_reg == ST_IDLE) && !trigger_valid
                          && pad_needed;
   assign block_close   = (state_reg == ST_IDLE) && !trigger_valid
                          && block_end && block_aligned;
   assign pad_done      = (state_reg == ST_PAD) && (state_next == ST_IDLE);

   // Trigger time pair, window and status word images
   always @* begin
      time_hi_word = 32'h0000_0000;
      time_hi_word[`WORD_DEFINING_BIT] = 1'b1;
      time_hi_word[`TYPE_TAG_HI:`TYPE_TAG_LO] = `TAG_TRIG_TIME;
      time_hi_word[`STAMP_HALF-1:0] =
         stamp_reg[`STAMP_WIDTH-1:`STAMP_HALF];
      time_lo_word = 32'h0000_0000;
      time_lo_word[31:24] = `CONT_HEAD;
      time_lo_word[`STAMP_HALF-1:0] = stamp_reg[`STAMP_HALF-1:0];
      window_word = 32'h0000_0000;
      window_word[31:24] = `WINDOW_HEAD;
      // Open tick inclusive, close tick exclusive
      window_word[23:16] = close_reg;
      window_word[7:0] = open_reg;
      no_data_word = 32'h0000_0000;
      no_data_word[`WORD_DEFINING_BIT] = 1'b1;
      no_data_word[`TYPE_TAG_HI:`TYPE_TAG_LO] = `TAG_NO_DATA;
      filler_word = 32'h0000_0000;
      filler_word[`WORD_DEFINING_BIT] = 1'b1;
      filler_word[`TYPE_TAG_HI:`TYPE_TAG_LO] = `TAG_FILLER;
   end

   // Hit word image
   always @* begin
      hit_word = 32'h0000_0000;
      hit_word[`WORD_DEFINING_BIT] = 1'b1;
      hit_word[`TYPE_TAG_HI:`TYPE_TAG_LO] = `TAG_HIT;
      hit_word[`HIT_ZERO_BIT] = 1'b0;
      hit_word[`HIT_CARRIER_BIT] = carrier_select;
      hit_word[`HIT_CHIP_LO +: CHIP_WIDTH] = frontend_chip_number;
      hit_word[`HIT_CHAN_LO +: CHAN_WIDTH] = channel_index;
      hit_word[`HIT_TICK_LO +: TICK_WIDTH] = hit_crossing_tick;
      hit_word[AMP_WIDTH-1:0] = hit_amplitude;
   end

   // Word sequencing
   always @* begin
      state_next  = state_reg;
      word_next   = word_data;
      valid_next  = 1'b0;
      filler_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (trigger_valid) begin
               state_next = ST_TIME1;
            end else if (pad_needed) begin
               state_next = ST_PAD;
            end else if (read_req) begin
               // Single read, nothing built; no register space here
               word_next  = no_data_word;
               valid_next = 1'b1;
            end
         end
         ST_TIME1: begin
            word_next  = time_hi_word;
            valid_next = 1'b1;
            state_next = ST_TIME2;
         end
         ST_TIME2: begin
            word_next  = time_lo_word;
            valid_next = 1'b1;
            state_next = ST_WIN;
         end
         ST_WIN: begin
            word_next  = window_word;
            valid_next = 1'b1;
            state_next = ST_HITS;
         end
         ST_HITS: begin
            // One word per clock keeps the full readout rate
            if (hit_valid) begin
               word_next  = hit_word;
               valid_next = 1'b1;
               if (hit_last) begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_PAD: begin
            word_next   = filler_word;
            valid_next  = 1'b1;
            filler_next = 1'b1;
            if (((count_reg + 2'd1) & align_reg) == 2'b00) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Sequencer state and registered outputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg      <= ST_IDLE;
         event_busy     <= 1'b0;
         word_valid     <= 1'b0;
         word_data      <= 32'h0000_0000;
         word_is_filler <= 1'b0;
      end else begin
         state_reg      <= state_next;
         word_valid     <= valid_next;
         word_data      <= word_next;
         word_is_filler <= filler_next;
         event_busy     <= (state_next != ST_IDLE);
      end
   end

   // Stamp and window ticks held from trigger acceptance
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stamp_reg <= `STAMP_RESET;
         open_reg  <= {TICK_WIDTH{1'b0}};
         close_reg <= {TICK_WIDTH{1'b0}};
      end else if (event_start) begin
         stamp_reg <= stamp;
         open_reg  <= window_open_tick;
         close_reg <= window_close_tick;
      end
   end

   // Pad modulus kept for the whole pad run
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         align_reg <= `ALIGN_MASK_2;
      end else if (pad_start) begin
         align_reg <= align_mask;
      end
   end

   // Block word count; no-data words stand outside blocks
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 2'b00;
      end else if (pad_done || block_close) begin
         count_reg <= 2'b00;
      end else if (valid_next && state_reg != ST_IDLE) begin
         count_reg <= count_reg + 2'd1;
      end
   end

endmodule // event_readout_word_encoder

/* File: test/event_word_checker_props.sv */
`timescale 1ns/1ps
module event_word_checker (
   input logic        clk,
   input logic        reset_n,
   input logic        trigger_valid,
   input logic [7:0]  window_open_tick,
   input logic [7:0]  window_close_tick,
   input logic        hit_valid,
   input logic [2:0]  hit_amplitude,
   input logic        block_end,
   input logic        read_req,
   input logic        event_busy,
   input logic        word_valid,
   input logic [31:0] word_data,
   input logic        word_is_filler
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence take_s; trigger_valid && !event_busy; endsequence
   time_hi_a: assert property (
      take_s |-> ##2 word_valid && word_data[31:24] == 8'h98)
      else $error("bad first time word");
   time_lo_a: assert property (
      take_s |-> ##3 word_valid && word_data[31:24] == 8'h00)
      else $error("bad second time word");
   window_a: assert property (take_s |-> ##4 word_valid &&
      word_data == {8'hA0, $past(window_close_tick, 4), 8'h00,
      $past(window_open_tick, 4)}) else $error("bad window word");
   busy_a: assert property (take_s |=> event_busy[*3])
      else $error("busy not held");
   hit_a: assert property (
      hit_valid && event_busy && $past(event_busy, 3) |-> ##1
      word_valid && word_data[31:23] == 9'h180 &&
      word_data[2:0] == $past(hit_amplitude)) else $error("bad hit");
   nodata_a: assert property (
      !event_busy && read_req && !trigger_valid && !block_end |=>
      word_valid && word_data == 32'hF000_0000) else $error("no-data");
   filler_a: assert property (word_is_filler |->
      word_valid && word_data == 32'hF800_0000) else $error("filler");
   cont_a: assert property (
      word_valid && !word_data[31] |-> $past(word_valid))
      else $error("orphan continuation");
endmodule // event_word_checker
bind event_readout_word_encoder event_word_checker chk_u (.*);

/* File: test/readout_host_model.sv */
`timescale 1ns/1ps
module readout_host_model (
   input  logic clk,
   output logic read_req = 1'b0,
   output logic block_end = 1'b0,
   output logic align_four = 1'b0
);
   // One-edge request; single 32-bit reads only
   task automatic pulse(input logic pad, input logic four);
      @(posedge clk);
      read_req <= !pad;
      block_end <= pad;
      align_four <= four;
      @(posedge clk);
      read_req <= 1'b0;
      block_end <= 1'b0;
   endtask
endmodule // readout_host_model

/* File: test/test_event_readout_word_encoder.sv */
`timescale 1ns/1ps
module test_event_readout_word_encoder;
   logic        clk = 1'b0, reset_n = 1'b0, trigger_valid = 1'b0;
   logic        hit_valid = 1'b0, hit_last = 1'b0, carrier_select = 1'b0;
   logic [2:0]  frontend_chip_number = 3'h0, hit_amplitude = 3'h0;
   logic [6:0]  channel_index = 7'h00;
   logic [7:0]  hit_crossing_tick = 8'h00, window_open_tick = 8'h10;
   logic [7:0]  window_close_tick = 8'h20;
   logic        read_req, block_end, align_four, event_busy, word_valid;
   logic        word_is_filler;
   logic [31:0] word_data, got[$];
   logic [47:0] s1, s2;
   int          fails = 0, num_checks = 0, t1, t2;
   event_readout_word_encoder dut_u (.*);
   readout_host_model host_u (.*);
   always #10 clk = ~clk;
   always @(posedge clk)
      if (word_valid) got.push_back(word_data);
   function automatic logic [21:0] hit_fields(int i);
      return {i[0], 3'h5 + i[2:0], 7'h7F - i[6:0], 8'hAB ^ i[7:0], 3'h7 - i[2:0]};
   endfunction
   task automatic check(string what, logic [31:0] exp, logic [31:0] act);
      num_checks++;
      fails += (act !== exp);
      if (act !== exp) $display("BAD %s exp %h got %h", what, exp, act);
   endtask
   task automatic settle();
      @(posedge clk);
      for (int i = 0; i < 60 && event_busy !== 1'b0; i++) @(posedge clk);
      if (event_busy !== 1'b0) begin
         fails++;
         $display("BAD settle exp busy 0 got %b", event_busy);
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic req_check(logic pad, logic four, int n, logic [31:0] w);
      got.delete();
      host_u.pulse(pad, four);
      settle();
      check("count", n, got.size());
      foreach (got[i]) check("word", w, got[i]);
   endtask
   // Trigger held while busy must be ignored
   task automatic run_event(int n, output logic [47:0] st, output int t);
      logic [21:0] f;
      got.delete();
      @(posedge clk);
      trigger_valid <= 1'b1;
      t = int'($time / 20);
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         {carrier_select, frontend_chip_number, channel_index,
            hit_crossing_tick, hit_amplitude} <= hit_fields(i);
         hit_valid <= 1'b1;
         hit_last <= (i == n - 1);
         trigger_valid <= 1'b0;
         @(posedge clk);
      end
      hit_valid <= 1'b0;
      hit_last <= 1'b0;
      settle();
      check("size", n + 3, got.size());
      check("time hi", 32'h9800_0000, got[0]);
      check("time lo", 8'h00, got[1][31:24]);
      check("window", 32'hA020_0010, got[2]);
      for (int i = 0; i < n; i++) begin
         f = hit_fields(i);
         check("hit", {9'h180, f[21:11], 1'b0, f[10:0]}, got[3 + i]);
      end
      st = {got[0][23:0], got[1][23:0]};
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20us fails++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      req_check(1'b0, 1'b0, 1, 32'hF000_0000);
      run_event(2, s1, t1);
      req_check(1'b1, 1'b1, 3, 32'hF800_0000);
      run_event(1, s2, t2);
      check("stamp step", t2 - t1, s2[31:0] - s1[31:0]);
      run_event(2, s1, t1);
      req_check(1'b1, 1'b0, 1, 32'hF800_0000);
      req_check(1'b0, 1'b0, 1, 32'hF000_0000);
      run_event(3, s2, t2);
      req_check(1'b1, 1'b1, 2, 32'hF800_0000);
      req_check(1'b1, 1'b0, 0, 32'hF800_0000);
      tally_and_finish();
   end
endmodule // test_event_readout_word_encoder
